// ---- verilog/gfx_dram_device.sv ----
// memory end: command decode, bank state, power states, ddr data pins
`timescale 1ns/100ps
// Behaviour
// - commands captured on ck rising edge only
// - read data changes on both ck edges
// - controller keeps ck running outside self-refresh
// - cke low blocks commands and read drivers; ck still clocks the device
// - cke low picks precharge, active or self-refresh
// - cke sampled; self-refresh exit is asynchronous
// - cke stays high through reads and writes
// - power-down ignores inputs except ck, cke
// - chip select high masks the command
// - command from cs, ras, cas, we
// - masked write bytes keep stored value
// - bank select picks one of eight
// - precharge bit high closes all banks
// - row on activate; column, auto-precharge on access
// - mode set loads address pins
// - read strobe edge-aligned with read data
// - write strobe centred in each data bit
// - data bus driven only by its writer
// - lane n uses strobe n, mask n
module gfx_dram_device
	import dram_pin_pkg::*;
#(
	parameter int ROW_W = 1,
	parameter int COL_W = 2
) (
	// link clock and control
	input wire logic ck_link,
	input wire logic sys_rst,
	input wire logic clk_en,
	// pins
	dram_pin_if.memory_end pins,
	// status
	output pwr_t power_state,
	output logic self_refresh,
	output logic [NUM_BANKS-1:0] open_banks,
	output logic [ADDR_W-1:0] mode_word
);

	localparam int IDX_W = BANK_W + ROW_W + COL_W;
	localparam int DEPTH = 1 << IDX_W;
	localparam int BEAT_W = DATA_W + LANES;

	typedef struct packed {
		pwr_t pwr;
		logic [NUM_BANKS-1:0] open;
		logic [NUM_BANKS-1:0][ADDR_W-1:0] row;
		logic [ADDR_W-1:0] mode;
		logic wr_wait;
		logic wr_commit;
		logic [IDX_W-1:0] wr_idx;
		logic [BEAT_W-1:0] wr_lo;
		logic rd_wait;
		logic [2*DATA_W-1:0] rd_buf;
		logic [BEAT_W-1:0] rd_pos;
		logic dq_oe;
		logic [DEPTH-1:0][2*DATA_W-1:0] mem;
	} dev_state_t;

	dev_state_t st;
	dev_state_t next_st;
	logic [BEAT_W-1:0] fall_cap;
	logic [BEAT_W-1:0] rd_neg;
	cmd_t cmd;
	logic sr_entry;
	logic cmd_live;
	logic [BANK_W-1:0] bank;
	logic [ADDR_W-1:0] addr;
	logic [2*DATA_W-1:0] wdata;
	logic [2*LANES-1:0] wmask;

	// column bits 0..7 and 9; bit 8 is auto-precharge
	function automatic logic [IDX_W-1:0] mem_index(
		input logic [BANK_W-1:0] b,
		input logic [ADDR_W-1:0] row,
		input logic [ADDR_W-1:0] a
	);
		logic [COL_W_FULL-1:0] col;
		col = {a[COL_HIGH_POS], a[PRECHARGE_ALL_POS-1:0]};
		mem_index = {b, row[ROW_W-1:0], col[COL_W-1:0]};
	endfunction

	// ****************************************
	// command sampling
	// ****************************************
	assign cmd = decode_cmd({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n});
	assign bank = pins.bank_select;
	assign addr = pins.address_pins;
	// only ck and cke matter while powered down or refreshing
	assign cmd_live = pins.cke && !self_refresh && (st.pwr == PWR_ACTIVE);
	assign sr_entry = !self_refresh && (st.pwr == PWR_ACTIVE) && !pins.cke
		&& (cmd == DEC_REFRESH) && (st.open == '0);
	assign wdata = {fall_cap[BEAT_W-1:LANES], st.wr_lo[BEAT_W-1:LANES]};
	assign wmask = {fall_cap[LANES-1:0], st.wr_lo[LANES-1:0]};

	// ****************************************
	// outputs
	// ****************************************
	// two flops per bit, xor-combined, so the pin can change on both edges
	assign pins.mem_data = st.rd_pos[BEAT_W-1:LANES] ^ rd_neg[BEAT_W-1:LANES];
	assign pins.mem_data_oe = st.dq_oe;
	assign pins.read_strobe = (st.rd_pos[LANES-1:0] ^ rd_neg[LANES-1:0])
		& {LANES{st.dq_oe}};
	assign power_state = st.pwr;
	assign open_banks = st.open;
	assign mode_word = st.mode;

	// ****************************************
	// rising-edge logic
	// ****************************************
	always_comb begin
		next_st = st;
		next_st.wr_commit = 1'b0;
		next_st.dq_oe = 1'b0;
		// both beats known by the next rise; masked bytes untouched
		if (st.wr_commit) begin
			for (int i = 0; i < 2*LANES; i++) begin
				if (!wmask[i]) begin
					next_st.mem[st.wr_idx][i*LANE_W +: LANE_W] = wdata[i*LANE_W +: LANE_W];
				end
			end
		end
		if (st.wr_wait) begin
			next_st.wr_lo = {pins.data_lines, pins.write_byte_mask};
			next_st.wr_commit = 1'b1;
			next_st.wr_wait = 1'b0;
		end
		if (st.rd_wait) begin
			// drivers stay off if cke has dropped
			next_st.rd_pos = {st.rd_buf[DATA_W-1:0], {LANES{1'b1}}} ^ rd_neg;
			next_st.dq_oe = pins.cke;
			next_st.rd_wait = 1'b0;
		end
		if (!self_refresh) begin
			unique case (st.pwr)
				PWR_PRE_PD, PWR_ACT_PD: begin
					if (pins.cke) begin
						next_st.pwr = PWR_ACTIVE;
					end
				end
				PWR_ACTIVE: begin
					if (!pins.cke) begin
						if (!sr_entry) begin
							next_st.pwr = (st.open == '0) ? PWR_PRE_PD : PWR_ACT_PD;
						end
					end else if (cmd_live) begin
						unique case (cmd)
							DEC_MODE: next_st.mode = addr;
							DEC_ACTIVATE: begin
								next_st.open[bank] = 1'b1;
								next_st.row[bank] = addr;
							end
							DEC_PRECHARGE: begin
								if (addr[PRECHARGE_ALL_POS]) begin
									next_st.open = '0;
								end else begin
									next_st.open[bank] = 1'b0;
								end
							end
							DEC_WRITE: begin
								if (st.open[bank]) begin
									next_st.wr_wait = 1'b1;
									next_st.wr_idx = mem_index(bank, st.row[bank], addr);
									if (addr[PRECHARGE_ALL_POS]) begin
										next_st.open[bank] = 1'b0;
									end
								end
							end
							DEC_READ: begin
								if (st.open[bank]) begin
									next_st.rd_wait = 1'b1;
									next_st.rd_buf = st.mem[mem_index(bank, st.row[bank], addr)];
									if (addr[PRECHARGE_ALL_POS]) begin
										next_st.open[bank] = 1'b0;
									end
								end
							end
							DEC_DESELECT, DEC_NOP, DEC_REFRESH, DEC_TERMINATE: begin
							end
						endcase
					end
				end
			endcase
		end
	end

	// commands and address taken on the rising edge only
	always_ff @(posedge ck_link) begin
		if (sys_rst) begin
			st <= '0;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	// ****************************************
	// falling-edge capture and read launch
	// ****************************************
	always_ff @(negedge ck_link) begin
		if (sys_rst) begin
			fall_cap <= '0;
			rd_neg <= '0;
		end else if (clk_en) begin
			fall_cap <= {pins.data_lines, pins.write_byte_mask};
			rd_neg <= {st.rd_buf[2*DATA_W-1:DATA_W], {LANES{1'b0}}} ^ st.rd_pos;
		end
	end

	// ****************************************
	// self-refresh flag
	// ****************************************
	// entry is sampled, exit needs no clock edge at all
	always_ff @(posedge ck_link or posedge pins.cke) begin
		if (pins.cke) begin
			self_refresh <= 1'b0;
		end else if (sys_rst) begin
			self_refresh <= 1'b0;
		end else if (clk_en && sr_entry) begin
			self_refresh <= 1'b1;
		end
	end

endmodule

// ---- verilog/dram_pin_pkg.sv ----
// shared constants, types and command decode for the dram pin link
package dram_pin_pkg;

	// ****************************************
	// bus shape
	// ****************************************
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	localparam int BANK_W = 3;
	localparam int NUM_BANKS = 8;
	localparam int ADDR_W = 12;
	localparam int PRECHARGE_ALL_POS = 8;
	localparam int COL_HIGH_POS = 9;
	localparam int COL_W_FULL = 9;

	// ****************************************
	// command codes {cs_n, ras_n, cas_n, we_n}
	// ****************************************
	localparam logic [3:0] CMD_MODE = 4'h0;
	localparam logic [3:0] CMD_REFRESH = 4'h1;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_ACTIVATE = 4'h3;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_TERMINATE = 4'h6;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_DESELECT = 4'hf;

	// ****************************************
	// reset values and controller timing, in sys_clk cycles
	// ****************************************
	localparam logic CKE_RESET = 1'b1;
	localparam int CK_PHASES = 4;
	localparam logic [3:0] STEP_CMD_END = 4'h4;
	localparam logic [3:0] STEP_WR_A = 4'h5;
	localparam logic [3:0] STEP_STROBE_HI = 4'h6;
	localparam logic [3:0] STEP_WR_B = 4'h7;
	localparam logic [3:0] STEP_STROBE_LO = 4'h8;
	localparam logic [3:0] STEP_WR_END = 4'h9;
	localparam logic [3:0] STEP_RD_A = 4'h8;
	localparam logic [3:0] STEP_LAST = 4'ha;

	typedef enum logic [3:0] {
		DEC_DESELECT, DEC_NOP, DEC_MODE, DEC_REFRESH, DEC_PRECHARGE,
		DEC_ACTIVATE, DEC_WRITE, DEC_READ, DEC_TERMINATE
	} cmd_t;

	typedef enum logic [1:0] {PWR_ACTIVE, PWR_PRE_PD, PWR_ACT_PD} pwr_t;

	typedef enum logic [3:0] {
		OP_MODE, OP_ACTIVATE, OP_PRECHARGE, OP_READ, OP_WRITE, OP_REFRESH,
		OP_PD_ENTER, OP_PD_EXIT, OP_SR_ENTER, OP_SR_EXIT
	} op_t;

	function automatic cmd_t decode_cmd(input logic [3:0] code);
		unique case (code)
			CMD_MODE: decode_cmd = DEC_MODE;
			CMD_REFRESH: decode_cmd = DEC_REFRESH;
			CMD_PRECHARGE: decode_cmd = DEC_PRECHARGE;
			CMD_ACTIVATE: decode_cmd = DEC_ACTIVATE;
			CMD_WRITE: decode_cmd = DEC_WRITE;
			CMD_READ: decode_cmd = DEC_READ;
			CMD_TERMINATE: decode_cmd = DEC_TERMINATE;
			CMD_NOP: decode_cmd = DEC_NOP;
			default: decode_cmd = DEC_DESELECT;
		endcase
	endfunction

endpackage

// ---- verilog/dram_pin_if.sv ----
// pin bundle between the dram controller and the dram device
`timescale 1ns/100ps
interface dram_pin_if;
	import dram_pin_pkg::*;

	logic ck;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [BANK_W-1:0] bank_select;
	logic [ADDR_W-1:0] address_pins;
	logic [LANES-1:0] write_byte_mask;
	logic [LANES-1:0] write_strobe;
	logic [LANES-1:0] read_strobe;
	logic [DATA_W-1:0] ctl_data;
	logic ctl_data_oe;
	logic [DATA_W-1:0] mem_data;
	logic mem_data_oe;
	logic [DATA_W-1:0] data_lines;

	// resolved shared wire; a clash shows as the controller's value
	// nobody driving reads as zero, there is no floating level in logic
	assign data_lines = ctl_data_oe ? ctl_data : (mem_data_oe ? mem_data : '0);

	modport controller_end (
		output ck, cke, cs_n, ras_n, cas_n, we_n, bank_select, address_pins,
		output write_byte_mask, write_strobe, ctl_data, ctl_data_oe,
		input data_lines
	);

	modport memory_end (
		input cke, cs_n, ras_n, cas_n, we_n, bank_select, address_pins,
		input write_byte_mask, write_strobe, data_lines,
		output read_strobe, mem_data, mem_data_oe
	);

endinterface

// ---- verilog/gfx_dram_controller.sv ----
// controller end: makes the link clock, sequences commands and data
`timescale 1ns/100ps
module gfx_dram_controller
	import dram_pin_pkg::*;
(
	// clock and control
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// request
	input wire logic req_valid,
	output logic req_ready,
	input wire op_t req_op,
	input wire logic [BANK_W-1:0] req_bank,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [2*DATA_W-1:0] req_wdata,
	input wire logic [2*LANES-1:0] req_wmask,
	// read answer
	output logic rsp_valid,
	output logic [2*DATA_W-1:0] rsp_data,
	// pins
	dram_pin_if.controller_end pins
);

	typedef struct packed {
		logic [1:0] ph;
		logic ck;
		logic busy;
		op_t op;
		logic [3:0] step;
		logic cke;
		logic [3:0] cmd;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
		logic [2*DATA_W-1:0] wdata;
		logic [2*LANES-1:0] wmask;
		logic [DATA_W-1:0] dq;
		logic dq_oe;
		logic [LANES-1:0] strobe;
		logic [LANES-1:0] mask;
		logic [DATA_W-1:0] s1;
		logic [DATA_W-1:0] s2;
		logic [DATA_W-1:0] rd_lo;
		logic rsp_valid;
		logic [2*DATA_W-1:0] rsp_data;
		logic req_ready;
	} ctl_state_t;

	ctl_state_t st;
	ctl_state_t next_st;

	// ****************************************
	// pins and user outputs
	// ****************************************
	assign pins.ck = st.ck;
	assign pins.cke = st.cke;
	assign {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = st.cmd;
	assign pins.bank_select = st.bank;
	assign pins.address_pins = st.addr;
	assign pins.ctl_data = st.dq;
	assign pins.ctl_data_oe = st.dq_oe;
	assign pins.write_strobe = st.strobe;
	assign pins.write_byte_mask = st.mask;
	assign req_ready = st.req_ready;
	assign rsp_valid = st.rsp_valid;
	assign rsp_data = st.rsp_data;

	// ****************************************
	// sequencer
	// ****************************************
	always_comb begin
		next_st = st;
		next_st.ph = st.ph + 2'h1;
		// ck high in phases 0 and 1; its edges sit mid-way between data changes
		next_st.ck = ~next_st.ph[1];
		next_st.s1 = pins.data_lines;
		next_st.s2 = st.s1;
		next_st.rsp_valid = 1'b0;
		if (!st.busy) begin
			if (req_valid && st.req_ready) begin
				next_st.busy = 1'b1;
				next_st.step = 4'h0;
				next_st.op = req_op;
				next_st.bank = req_bank;
				next_st.addr = req_addr;
				next_st.wdata = req_wdata;
				next_st.wmask = req_wmask;
				// cke only moves on power requests, so it stays high through accesses
				unique case (req_op)
					OP_MODE: next_st.cmd = CMD_MODE;
					OP_ACTIVATE: next_st.cmd = CMD_ACTIVATE;
					OP_PRECHARGE: next_st.cmd = CMD_PRECHARGE;
					OP_READ: next_st.cmd = CMD_READ;
					OP_WRITE: next_st.cmd = CMD_WRITE;
					OP_REFRESH: next_st.cmd = CMD_REFRESH;
					OP_PD_ENTER: begin
						next_st.cmd = CMD_NOP;
						next_st.cke = 1'b0;
					end
					OP_PD_EXIT, OP_SR_EXIT: begin
						next_st.cmd = CMD_NOP;
						next_st.cke = 1'b1;
					end
					OP_SR_ENTER: begin
						next_st.cmd = CMD_REFRESH;
						next_st.cke = 1'b0;
					end
				endcase
			end
		end else begin
			next_st.step = st.step + 4'h1;
			// back to deselect once the memory has taken the command
			if (next_st.step == STEP_CMD_END) begin
				next_st.cmd = CMD_DESELECT;
			end
			if (st.op == OP_WRITE) begin
				// data changes in mid-phase, strobe edges on ck edges
				if (next_st.step == STEP_WR_A) begin
					next_st.dq = st.wdata[DATA_W-1:0];
					next_st.mask = st.wmask[LANES-1:0];
					next_st.dq_oe = 1'b1;
				end
				if (next_st.step == STEP_STROBE_HI) begin
					next_st.strobe = '1;
				end
				if (next_st.step == STEP_WR_B) begin
					next_st.dq = st.wdata[2*DATA_W-1:DATA_W];
					next_st.mask = st.wmask[2*LANES-1:LANES];
				end
				if (next_st.step == STEP_STROBE_LO) begin
					next_st.strobe = '0;
				end
				if (next_st.step == STEP_WR_END) begin
					next_st.dq_oe = 1'b0;
					next_st.mask = '0;
				end
			end
			if (st.step == STEP_RD_A) begin
				next_st.rd_lo = st.s2;
			end
			if (st.step == STEP_LAST) begin
				next_st.busy = 1'b0;
				next_st.rsp_valid = (st.op == OP_READ);
				next_st.rsp_data = {st.s2, st.rd_lo};
			end
		end
		next_st.req_ready = !next_st.busy && (next_st.ph == 2'h1);
	end

	// clock kept running whenever out of reset with clk_en high, self-refresh included
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st <= '0;
			st.cke <= CKE_RESET;
			st.cmd <= CMD_DESELECT;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

endmodule

// ---- testbench/dram_pin_monitor.sv ----
// concurrent checks on the pins between the controller and the device
`timescale 1ns/100ps
module dram_pin_monitor
	import dram_pin_pkg::*;
(
	// clocks and resets
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ck,
	input wire logic link_rst,
	// command pins
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	// data pins
	input wire logic [LANES-1:0] write_byte_mask,
	input wire logic [LANES-1:0] write_strobe,
	input wire logic [LANES-1:0] read_strobe,
	input wire logic ctl_data_oe,
	input wire logic mem_data_oe,
	input wire logic [DATA_W-1:0] data_lines
);
	wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};

	// ****************************************
	// link domain
	// ****************************************
	a_read_after_cmd: assert property (@(posedge ck) disable iff (link_rst)
		$rose(mem_data_oe) |-> $past(cmd, 2) == CMD_READ && $past(cke, 2))
		else $error("read drivers on without a read command");
	a_read_one_ck: assert property (@(posedge ck) disable iff (link_rst)
		mem_data_oe |=> !mem_data_oe)
		else $error("read drivers held past one link cycle");
	a_strobe_first_beat: assert property (@(negedge ck) disable iff (link_rst)
		mem_data_oe |-> read_strobe == 4'hf)
		else $error("read strobe low during first beat");
	a_strobe_second_beat: assert property (@(posedge ck) disable iff (link_rst)
		mem_data_oe |-> read_strobe == 4'h0)
		else $error("read strobe high during second beat");
	a_cke_in_access: assert property (@(posedge ck) disable iff (link_rst)
		(ctl_data_oe || mem_data_oe) |-> cke)
		else $error("clock enable low during data transfer");

	// ****************************************
	// system domain
	// ****************************************
	a_no_bus_clash: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!(ctl_data_oe && mem_data_oe))
		else $error("both ends drive the data lines");
	a_strobe_centred: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$changed(write_strobe) |-> $stable(data_lines) && ctl_data_oe)
		else $error("write strobe moved with the data");
	a_mask_with_data: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(|write_byte_mask) |-> ctl_data_oe)
		else $error("byte mask set outside write data");
	a_idle_deselect: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cs_n |-> ras_n && cas_n && we_n)
		else $error("command lines active while deselected");
	a_cmd_in_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$changed(cmd) |-> !ck)
		else $error("command changed while link clock high");
endmodule

// ---- testbench/tb_top.sv ----
// self-checking bench joining the controller and device ends
`timescale 1ns/100ps
module tb_top;
	import dram_pin_pkg::*;

	// ****************************************
	// operation table
	// ****************************************
	typedef struct {
		op_t op;
		logic [2:0] bank;
		logic [11:0] addr;
		logic [63:0] wd;
		logic [7:0] wm;
		logic rd;
		logic [7:0] open;
		pwr_t pwr;
		logic sr;
	} row_t;
	localparam logic [63:0] W1 = 64'h1111_2222_3333_4444;
	localparam logic [63:0] W2 = 64'haaaa_bbbb_cccc_dddd;
	// masked bytes keep the first write's value
	localparam logic [63:0] RD = 64'haa11_bb22_33cc_44dd;
	localparam logic [63:0] Z = 64'h0;
	row_t rows [20] = '{
		'{OP_MODE, 3'h0, 12'h123, Z, 8'h00, 1'h0, 8'h00, PWR_ACTIVE, 1'h0},
		'{OP_ACTIVATE, 3'h3, 12'h001, Z, 8'h00, 1'h0, 8'h08, PWR_ACTIVE, 1'h0},
		'{OP_ACTIVATE, 3'h5, 12'h000, Z, 8'h00, 1'h0, 8'h28, PWR_ACTIVE, 1'h0},
		'{OP_WRITE, 3'h3, 12'h002, W1, 8'h00, 1'h0, 8'h28, PWR_ACTIVE, 1'h0},
		'{OP_WRITE, 3'h3, 12'h002, W2, 8'h5a, 1'h0, 8'h28, PWR_ACTIVE, 1'h0},
		'{OP_READ, 3'h3, 12'h002, RD, 8'h00, 1'h1, 8'h28, PWR_ACTIVE, 1'h0},
		'{OP_READ, 3'h5, 12'h002, Z, 8'h00, 1'h1, 8'h28, PWR_ACTIVE, 1'h0},
		'{OP_READ, 3'h3, 12'h102, RD, 8'h00, 1'h1, 8'h20, PWR_ACTIVE, 1'h0},
		'{OP_READ, 3'h3, 12'h002, Z, 8'h00, 1'h0, 8'h20, PWR_ACTIVE, 1'h0},
		'{OP_PRECHARGE, 3'h5, 12'h000, Z, 8'h00, 1'h0, 8'h00, PWR_ACTIVE, 1'h0},
		'{OP_PD_ENTER, 3'h0, 12'h000, Z, 8'h00, 1'h0, 8'h00, PWR_PRE_PD, 1'h0},
		'{OP_ACTIVATE, 3'h2, 12'h000, Z, 8'h00, 1'h0, 8'h00, PWR_PRE_PD, 1'h0},
		'{OP_PD_EXIT, 3'h0, 12'h000, Z, 8'h00, 1'h0, 8'h00, PWR_ACTIVE, 1'h0},
		'{OP_ACTIVATE, 3'h1, 12'h000, Z, 8'h00, 1'h0, 8'h02, PWR_ACTIVE, 1'h0},
		'{OP_PD_ENTER, 3'h0, 12'h000, Z, 8'h00, 1'h0, 8'h02, PWR_ACT_PD, 1'h0},
		'{OP_PD_EXIT, 3'h0, 12'h000, Z, 8'h00, 1'h0, 8'h02, PWR_ACTIVE, 1'h0},
		'{OP_ACTIVATE, 3'h6, 12'h000, Z, 8'h00, 1'h0, 8'h42, PWR_ACTIVE, 1'h0},
		'{OP_PRECHARGE, 3'h0, 12'h100, Z, 8'h00, 1'h0, 8'h00, PWR_ACTIVE, 1'h0},
		'{OP_SR_ENTER, 3'h0, 12'h000, Z, 8'h00, 1'h0, 8'h00, PWR_ACTIVE, 1'h1},
		'{OP_SR_EXIT, 3'h0, 12'h000, Z, 8'h00, 1'h0, 8'h00, PWR_ACTIVE, 1'h0}
	};

	// ****************************************
	// signals and ends
	// ****************************************
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic link_rst = 1'b1;
	logic req_valid = 1'b0;
	op_t req_op = OP_MODE;
	logic [BANK_W-1:0] req_bank = 3'h0;
	logic [ADDR_W-1:0] req_addr = 12'h000;
	logic [2*DATA_W-1:0] req_wdata = 64'h0;
	logic [2*LANES-1:0] req_wmask = 8'h00;
	logic req_ready;
	logic rsp_valid;
	logic [2*DATA_W-1:0] rsp_data;
	pwr_t power_state;
	logic self_refresh;
	logic [NUM_BANKS-1:0] open_banks;
	logic [ADDR_W-1:0] mode_word;
	logic [63:0] got;
	logic [63:0] bus_view;
	int error_cnt = 0;
	int checks_done = 0;
	int oe_rises = 0;
	int n_rd = 0;

	dram_pin_if dram_pin_if_i();
	gfx_dram_controller gfx_dram_controller_i(.sys_clk(sys_clk), .sys_rst(sys_rst),
		.clk_en(1'b1), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
		.req_bank(req_bank), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_wmask(req_wmask), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.pins(dram_pin_if_i));
	gfx_dram_device gfx_dram_device_i(.ck_link(dram_pin_if_i.ck), .sys_rst(link_rst),
		.clk_en(1'b1), .pins(dram_pin_if_i), .power_state(power_state),
		.self_refresh(self_refresh), .open_banks(open_banks), .mode_word(mode_word));
	dram_pin_monitor dram_pin_monitor_i(.sys_clk(sys_clk), .sys_rst(sys_rst),
		.ck(dram_pin_if_i.ck), .link_rst(link_rst), .cke(dram_pin_if_i.cke),
		.cs_n(dram_pin_if_i.cs_n), .ras_n(dram_pin_if_i.ras_n), .cas_n(dram_pin_if_i.cas_n),
		.we_n(dram_pin_if_i.we_n), .write_byte_mask(dram_pin_if_i.write_byte_mask),
		.write_strobe(dram_pin_if_i.write_strobe), .read_strobe(dram_pin_if_i.read_strobe),
		.ctl_data_oe(dram_pin_if_i.ctl_data_oe), .mem_data_oe(dram_pin_if_i.mem_data_oe),
		.data_lines(dram_pin_if_i.data_lines));

	always #5 sys_clk = ~sys_clk;
	always @(posedge dram_pin_if_i.mem_data_oe) oe_rises++;
	assign bus_view = {30'h0, dram_pin_if_i.ctl_data_oe, dram_pin_if_i.mem_data_oe,
		dram_pin_if_i.data_lines};

	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] seen);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic do_op(input row_t r);
		int n;
		@(negedge sys_clk);
		req_op = r.op;
		req_bank = r.bank;
		req_addr = r.addr;
		req_wdata = r.wd;
		req_wmask = r.wm;
		req_valid = 1'b1;
		n = 0;
		while (req_ready !== 1'b1 && n < 40) begin
			@(negedge sys_clk);
			n++;
		end
		check("req_ready", 64'h1, {63'h0, req_ready});
		@(negedge sys_clk);
		req_valid = 1'b0;
		// no answer at all must not pass as a zero read
		got = 64'hffff_ffff_ffff_ffff;
		// 24 cycles covers the read answer and the spacing before the next request
		repeat (24) begin
			@(negedge sys_clk);
			if (rsp_valid === 1'b1) got = rsp_data;
		end
	endtask

	task automatic finish_test;
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		#100000;
		error_cnt++;
		finish_test();
	end

	initial begin
		repeat (3) @(negedge sys_clk);
		check("ck in reset", 64'h0, {63'h0, dram_pin_if_i.ck});
		check("cs_n in reset", 64'h1, {63'h0, dram_pin_if_i.cs_n});
		repeat (3) @(negedge sys_clk);
		sys_rst = 1'b0;
		// device reset is synchronous to the link clock, which runs only now
		repeat (16) @(negedge sys_clk);
		link_rst = 1'b0;
		repeat (8) @(negedge sys_clk);
		check("reset banks", 64'h0, {56'h0, open_banks});
		check("reset mode", 64'h0, {52'h0, mode_word});
		check("reset power", 64'(PWR_ACTIVE), {62'h0, power_state});
		check("lines in reset", 64'h0, bus_view);
		foreach (rows[i]) begin
			do_op(rows[i]);
			if (rows[i].rd === 1'b1) n_rd++;
			check("read count", 64'(n_rd), 64'(oe_rises));
			if (rows[i].rd === 1'b1) check("read data", rows[i].wd, got);
			check("open banks", {56'h0, rows[i].open}, {56'h0, open_banks});
			check("self refresh", {63'h0, rows[i].sr}, {63'h0, self_refresh});
			if (rows[i].sr !== 1'b1) check("power", {62'h0, rows[i].pwr}, {62'h0, power_state});
		end
		check("mode word", 64'h123, {52'h0, mode_word});
		check("lines idle", 64'h0, bus_view);
		// second reset: device first, while the controller still runs the link clock
		link_rst = 1'b1;
		repeat (12) @(negedge sys_clk);
		sys_rst = 1'b1;
		repeat (6) @(negedge sys_clk);
		check("ck in second reset", 64'h0, {63'h0, dram_pin_if_i.ck});
		check("cs_n in second reset", 64'h1, {63'h0, dram_pin_if_i.cs_n});
		check("mode after reset", 64'h0, {52'h0, mode_word});
		sys_rst = 1'b0;
		repeat (16) @(negedge sys_clk);
		link_rst = 1'b0;
		repeat (8) @(negedge sys_clk);
		do_op(rows[0]);
		check("mode after second reset", 64'h123, {52'h0, mode_word});
		finish_test();
	end
endmodule
